// File: rtl/rss_top.sv
// rail supervisor and power sequencer with APB registers
// Operation
// - main/core power-good: fault 10% low, 5% hysteresis
// - same power-good for both linear regulators
// - power-good results readable in status register
// - maskable interrupt when a rail drops low
// - main/core comparison off while converter off
// - second linear regulator comparison off when disabled
// - power-on reset follows main power-good
// - converter overtemp shutdown only in PWM
// - linear regulators on after reset, host-settable
// - lockout threshold 2.75 V, host reprogrammable
// - lockout blocks converter switch transistors
// - lockout: supply-fail low, delay, ordered shutdown
// - overtemperature: same shutdown with own delay
// - automatic restart once fault clears
// - charger lockout on adapter and USB supplies
// - sequence pin picks first up, last down
// - core default 1.5 V or 1.8 V
// - main default 3 V or 3.3 V
// - reset held 100 ms or 1 s
// - supply-fail low while reset held low
`include "rss_defs.svh"
module rss_top #(
    parameter int POR_SHORT_CYC = `RSS_POR_SHORT_CYC,
    parameter int POR_LONG_CYC = `RSS_POR_LONG_CYC
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [3:0] RAIL_BELOW,
    input wire logic [3:0] RAIL_RECOV,
    input wire logic UNDERVOLTAGE_LOCKOUT_DET,
    input wire logic OVERTEMP_DET,
    input wire logic CONV_OT_DET,
    input wire logic AUTO_PWM,
    input wire logic AC_LOW,
    input wire logic USB_LOW,
    input wire logic SEQUENCE_ORDER_PIN,
    input wire logic CORE_DEFAULT_STRAP,
    input wire logic MAIN_DEFAULT_STRAP,
    input wire logic RESET_DELAY_SELECT,
    output logic MAIN_RAIL_EN,
    output logic CORE_RAIL_EN,
    output logic LINEAR_REG_ONE_EN,
    output logic LINEAR_REG_TWO_EN,
    output logic [2:0] LINEAR_REG_ONE_VSEL,
    output logic [2:0] LINEAR_REG_TWO_VSEL,
    output logic [3:0] MAIN_RAIL_VSEL,
    output logic [3:0] CORE_RAIL_VSEL,
    output logic FORCED_PWM_BIT,
    output logic [1:0] UNDERVOLTAGE_LOCKOUT_SEL,
    output logic SWITCH_BLOCK,
    output logic CHARGER_LOCKOUT,
    output logic POWER_ON_RESET_OUT_N,
    output logic SUPPLY_FAIL_OUT_N,
    output logic INT_N
);
    localparam int PW = $clog2(POR_LONG_CYC + 1);
    localparam int DW = 12;

    rss_pg_if #(.N(4)) pg ();

    logic [9:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
    logic undervoltage_lockout_f, ot_f, conv_ot_f, auto_pwm_f, ac_low_f, usb_low_f;
    logic seq_pin_f, core_strap_f, main_strap_f, rds_f;
    logic [2:0] init_cnt_q;
    logic straps_taken_q, seq_order_q;
    logic [3:0] mask_q;
    logic [7:0] conv_reg_q;
    logic [10:0] ldo_reg_q;
    logic [1:0] undervoltage_lockout_code_q;
    logic [3:0] main_vsel_q, core_vsel_q;
    rss_pkg::rss_state_t state_q;
    logic [DW-1:0] dly_q;
    logic [1:0] seq_on_q;
    logic seq_ldo_q;
    logic fail, pwm_active, conv_ot_trip, por_done;
    logic [PW-1:0] por_cnt_q;
    logic [3:0] fault_live;
    logic apb_go, apb_wr;
    logic [31:0] rd_d;
    logic map_hit;

    function automatic logic [DW-1:0] cyc(input int n);
        cyc = DW'(n - 1);
    endfunction

    // three-stage capture of asynchronous pins, change on 2nd/3rd agreement
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pin_s1_q <= 10'h000;
            pin_s2_q <= 10'h000;
            pin_s3_q <= 10'h000;
        end else begin
            pin_s1_q <= {RESET_DELAY_SELECT, MAIN_DEFAULT_STRAP,
                CORE_DEFAULT_STRAP, SEQUENCE_ORDER_PIN, USB_LOW, AC_LOW,
                AUTO_PWM, CONV_OT_DET, OVERTEMP_DET,
                UNDERVOLTAGE_LOCKOUT_DET};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST)
            pin_f_q <= 10'h000;
        else
            pin_f_q <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q | pin_s3_q));
    end

    assign undervoltage_lockout_f = pin_f_q[0];
    assign ot_f = pin_f_q[1];
    assign conv_ot_f = pin_f_q[2];
    assign auto_pwm_f = pin_f_q[3];
    assign ac_low_f = pin_f_q[4];
    assign usb_low_f = pin_f_q[5];
    assign seq_pin_f = pin_f_q[6];
    assign core_strap_f = pin_f_q[7];
    assign main_strap_f = pin_f_q[8];
    assign rds_f = pin_f_q[9];

    // straps taken one edge after the filter settles, else reset value read
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            init_cnt_q <= 3'h0;
            straps_taken_q <= 1'b0;
            seq_order_q <= 1'b0;
        end else if (!straps_taken_q) begin
            init_cnt_q <= init_cnt_q + 3'h1;
            if (init_cnt_q == 3'h4) begin
                straps_taken_q <= 1'b1;
                seq_order_q <= seq_pin_f;
            end
        end
    end

    // apb: one wait state, so every answer comes from a flip-flop
    assign apb_go = PSEL && PENABLE && !PREADY;
    assign apb_wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    assign fault_live = pg.fault;

    always_comb begin
        map_hit = 1'b1;
        rd_d = 32'h0000_0000;
        case (PADDR)
            `RSS_ADDR_STATUS: rd_d = {20'h00000, por_done, 1'(state_q),
                2'(state_q >> 1), CHARGER_LOCKOUT, conv_ot_trip, ot_f,
                undervoltage_lockout_f, ~fault_live};
            `RSS_ADDR_MASK: rd_d = {28'h0000000, mask_q};
            `RSS_ADDR_CONV: rd_d = {24'h000000, conv_reg_q};
            `RSS_ADDR_LDO: rd_d = {21'h000000, ldo_reg_q};
            `RSS_ADDR_UNDERVOLTAGE_LOCKOUT: rd_d = {30'h00000000, undervoltage_lockout_code_q};
            `RSS_ADDR_VSEL: rd_d = {20'h00000, core_vsel_q, 4'h0,
                main_vsel_q};
            default: map_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= apb_go;
            PSLVERR <= apb_go && !map_hit;
            if (apb_go && !PWRITE)
                PRDATA <= rd_d;
        end
    end

    // host-written control; straps load the voltage defaults once
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            mask_q <= 4'h0;
            conv_reg_q <= `RSS_CONV_RESET;
            ldo_reg_q <= `RSS_LDO_RESET;
            undervoltage_lockout_code_q <= `RSS_UNDERVOLTAGE_LOCKOUT_CODE_2V75;
            main_vsel_q <= `RSS_MAIN_3V0;
            core_vsel_q <= `RSS_CORE_1V5;
        end else if (!straps_taken_q) begin
            if (init_cnt_q == 3'h4) begin
                main_vsel_q <= main_strap_f ? `RSS_MAIN_3V3
                    : `RSS_MAIN_3V0;
                core_vsel_q <= core_strap_f ? `RSS_CORE_1V8
                    : `RSS_CORE_1V5;
            end
        end else if (apb_wr) begin
            case (PADDR)
                `RSS_ADDR_MASK: mask_q <= PWDATA[3:0];
                `RSS_ADDR_CONV: conv_reg_q <= PWDATA[7:0];
                `RSS_ADDR_LDO: ldo_reg_q <= PWDATA[10:0];
                `RSS_ADDR_UNDERVOLTAGE_LOCKOUT: undervoltage_lockout_code_q <= PWDATA[1:0];
                `RSS_ADDR_VSEL: begin
                    main_vsel_q <= PWDATA[3:0];
                    core_vsel_q <= PWDATA[11:8];
                end
                default: ;
            endcase
        end
    end

    // converter overtemp is only trusted while switching in PWM
    assign pwm_active = conv_reg_q[`RSS_CONV_FORCED_PWM_BIT] || auto_pwm_f;
    assign conv_ot_trip = conv_ot_f && pwm_active;
    assign fail = undervoltage_lockout_f || ot_f;

    // sequencer: first-up rail is the last one down
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_q <= rss_pkg::ST_OFF;
            dly_q <= '0;
            seq_on_q <= 2'h0;
            seq_ldo_q <= 1'b0;
        end else begin
            if (dly_q != '0)
                dly_q <= dly_q - DW'(1);
            case (state_q)
                rss_pkg::ST_OFF: begin
                    if (straps_taken_q && !fail) begin
                        state_q <= rss_pkg::ST_UP1;
                        dly_q <= cyc(`RSS_STEP_CYC);
                        seq_on_q <= seq_order_q ? 2'h1 : 2'h2;
                    end
                end
                rss_pkg::ST_UP1: begin
                    if (fail) begin
                        state_q <= rss_pkg::ST_FAILDLY;
                        dly_q <= undervoltage_lockout_f ? cyc(`RSS_UNDERVOLTAGE_LOCKOUT_DLY_CYC)
                            : cyc(`RSS_OT_DLY_CYC);
                    end else if (dly_q == '0) begin
                        state_q <= rss_pkg::ST_UP2;
                        dly_q <= cyc(`RSS_STEP_CYC);
                        seq_on_q <= 2'h3;
                        seq_ldo_q <= 1'b1;
                    end
                end
                rss_pkg::ST_UP2, rss_pkg::ST_RUN: begin
                    if (fail) begin
                        state_q <= rss_pkg::ST_FAILDLY;
                        dly_q <= undervoltage_lockout_f ? cyc(`RSS_UNDERVOLTAGE_LOCKOUT_DLY_CYC)
                            : cyc(`RSS_OT_DLY_CYC);
                    end else if (dly_q == '0) begin
                        state_q <= rss_pkg::ST_RUN;
                    end
                end
                rss_pkg::ST_FAILDLY: begin
                    if (dly_q == '0) begin
                        state_q <= rss_pkg::ST_DN1;
                        dly_q <= cyc(`RSS_STEP_CYC);
                        seq_ldo_q <= 1'b0;
                        // drop the rail that came up last
                        seq_on_q <= seq_order_q ? 2'h1 : 2'h2;
                    end
                end
                rss_pkg::ST_DN1: begin
                    if (dly_q == '0) begin
                        state_q <= rss_pkg::ST_DN2;
                        seq_on_q <= 2'h0;
                    end
                end
                rss_pkg::ST_DN2: state_q <= rss_pkg::ST_OFF;
                default: state_q <= rss_pkg::ST_OFF;
            endcase
        end
    end

    // regulator enables; lockout and hot converters override sequencing
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            MAIN_RAIL_EN <= 1'b0;
            CORE_RAIL_EN <= 1'b0;
            LINEAR_REG_ONE_EN <= 1'b0;
            LINEAR_REG_TWO_EN <= 1'b0;
            SWITCH_BLOCK <= 1'b1;
        end else begin
            MAIN_RAIL_EN <= seq_on_q[`RSS_RAIL_MAIN] && !undervoltage_lockout_f
                && !conv_ot_trip && conv_reg_q[`RSS_CONV_MAIN_EN];
            CORE_RAIL_EN <= seq_on_q[`RSS_RAIL_CORE] && !undervoltage_lockout_f
                && !conv_ot_trip && conv_reg_q[`RSS_CONV_CORE_EN];
            LINEAR_REG_ONE_EN <= seq_ldo_q && ldo_reg_q[0];
            LINEAR_REG_TWO_EN <= seq_ldo_q && ldo_reg_q[1];
            SWITCH_BLOCK <= undervoltage_lockout_f;
        end
    end

    // comparisons follow the live enables, except linear regulator one, which is always compared
    assign pg.below = RAIL_BELOW;
    assign pg.recov = RAIL_RECOV;
    assign pg.enable = {LINEAR_REG_TWO_EN, 1'b1, CORE_RAIL_EN,
        MAIN_RAIL_EN};

    rss_pgood_mon #(.N(4)) u_pg (
        .clk(CLOCK),
        .rst(RST),
        .pg(pg)
    );

    // reset release waits out the selected delay after main is good
    assign por_done = por_cnt_q == (rds_f ? PW'(POR_LONG_CYC)
        : PW'(POR_SHORT_CYC));

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            por_cnt_q <= '0;
            POWER_ON_RESET_OUT_N <= 1'b0;
        end else if (fault_live[`RSS_RAIL_MAIN] || !MAIN_RAIL_EN) begin
            por_cnt_q <= '0;
            POWER_ON_RESET_OUT_N <= 1'b0;
        end else if (por_done) begin
            POWER_ON_RESET_OUT_N <= 1'b1;
        end else begin
            por_cnt_q <= por_cnt_q + PW'(1);
        end
    end

    // status outputs; interrupt is level, not sticky
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            SUPPLY_FAIL_OUT_N <= 1'b0;
            INT_N <= 1'b1;
            CHARGER_LOCKOUT <= 1'b1;
        end else begin
            SUPPLY_FAIL_OUT_N <= !(fail || !POWER_ON_RESET_OUT_N);
            INT_N <= !(|(fault_live & ~mask_q));
            CHARGER_LOCKOUT <= ac_low_f && usb_low_f;
        end
    end

    assign LINEAR_REG_ONE_VSEL = ldo_reg_q[6:4];
    assign LINEAR_REG_TWO_VSEL = ldo_reg_q[10:8];
    assign MAIN_RAIL_VSEL = main_vsel_q;
    assign CORE_RAIL_VSEL = core_vsel_q;
    assign FORCED_PWM_BIT = conv_reg_q[`RSS_CONV_FORCED_PWM_BIT];
    assign UNDERVOLTAGE_LOCKOUT_SEL = undervoltage_lockout_code_q;

    chk_por_main_bad: assert property (@(posedge CLOCK) disable iff (RST)
        fault_live[0] |=> !POWER_ON_RESET_OUT_N)
        else $error("reset released with main rail bad");
    chk_sf_during_por: assert property (@(posedge CLOCK) disable iff (RST)
        !POWER_ON_RESET_OUT_N |=> !SUPPLY_FAIL_OUT_N)
        else $error("supply fail high while reset held");
    chk_undervoltage_lockout_sf_first: assert property (@(posedge CLOCK) disable iff (RST)
        (state_q == rss_pkg::ST_RUN && undervoltage_lockout_f) |=> !SUPPLY_FAIL_OUT_N
        && state_q == rss_pkg::ST_FAILDLY ##1 seq_on_q == 2'h3 [*4])
        else $error("rails dropped before lockout delay");
    chk_undervoltage_lockout_block: assert property (@(posedge CLOCK) disable iff (RST)
        undervoltage_lockout_f |=> SWITCH_BLOCK && !MAIN_RAIL_EN && !CORE_RAIL_EN)
        else $error("converter switching during lockout");
    chk_int_raise: assert property (@(posedge CLOCK) disable iff (RST)
        (|(fault_live & ~mask_q)) |=> !INT_N)
        else $error("unmasked fault gave no interrupt");
    chk_int_masked: assert property (@(posedge CLOCK) disable iff (RST)
        !(|(fault_live & ~mask_q)) |=> INT_N)
        else $error("masked fault drove interrupt");
    chk_seq_order: assert property (@(posedge CLOCK) disable iff (RST)
        state_q == rss_pkg::ST_UP1 |-> seq_on_q
        == (seq_order_q ? 2'h1 : 2'h2))
        else $error("wrong converter ramped first");
    chk_conv_ot_pwm: assert property (@(posedge CLOCK) disable iff (RST)
        (conv_ot_f && pwm_active) |=> !MAIN_RAIL_EN && !CORE_RAIL_EN)
        else $error("converter on while hot in pwm");
    chk_ldo_default: assert property (@(posedge CLOCK)
        $fell(RST) |-> ldo_reg_q[1:0] == 2'h3 && undervoltage_lockout_code_q
        == `RSS_UNDERVOLTAGE_LOCKOUT_CODE_2V75)
        else $error("wrong linear regulator or lockout default");
    chk_restart: assert property (@(posedge CLOCK) disable iff (RST)
        (state_q == rss_pkg::ST_OFF && straps_taken_q && !fail)
        |=> state_q == rss_pkg::ST_UP1)
        else $error("no automatic restart");
endmodule

// File: rtl/rss_defs.svh
// offsets, field positions, reset values and timing counts of the supervisor
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

`define RSS_ADDR_STATUS 8'h00
`define RSS_ADDR_MASK 8'h04
`define RSS_ADDR_CONV 8'h08
`define RSS_ADDR_LDO 8'h0C
`define RSS_ADDR_UNDERVOLTAGE_LOCKOUT 8'h10
`define RSS_ADDR_VSEL 8'h14

`define RSS_RAIL_MAIN 0
`define RSS_RAIL_CORE 1
`define RSS_RAIL_LINEAR_REG_ONE 2
`define RSS_RAIL_LINEAR_REG_TWO 3

`define RSS_CONV_MAIN_EN 0
`define RSS_CONV_CORE_EN 1
`define RSS_CONV_FORCED_PWM_BIT 7
`define RSS_CONV_RESET 8'h03

`define RSS_LDO_RESET 11'h003

`define RSS_UNDERVOLTAGE_LOCKOUT_RESET_MV 2750
`define RSS_UNDERVOLTAGE_LOCKOUT_CODE_2V75 2'h3
`define RSS_CHG_LOCKOUT_MV 2500
`define RSS_OT_TRIP_DEGC 160

`define RSS_MAIN_3V0 4'h0
`define RSS_MAIN_3V3 4'h3
`define RSS_CORE_1V5 4'h5
`define RSS_CORE_1V8 4'h8

`define RSS_CLK_MHZ 250
`define RSS_POR_SHORT_MS 100
`define RSS_POR_LONG_MS 1000
`define RSS_UNDERVOLTAGE_LOCKOUT_DLY_US 5
`define RSS_OT_DLY_US 5
`define RSS_STEP_US 2
`define RSS_UNDERVOLTAGE_LOCKOUT_DLY_CYC (`RSS_UNDERVOLTAGE_LOCKOUT_DLY_US * `RSS_CLK_MHZ)
`define RSS_OT_DLY_CYC (`RSS_OT_DLY_US * `RSS_CLK_MHZ)
`define RSS_STEP_CYC (`RSS_STEP_US * `RSS_CLK_MHZ)
`define RSS_POR_SHORT_CYC (`RSS_POR_SHORT_MS * `RSS_CLK_MHZ * 1000)
`define RSS_POR_LONG_CYC (`RSS_POR_LONG_MS * `RSS_CLK_MHZ * 1000)

`endif

// File: rtl/rss_pkg.sv
// types of the supervisor
package rss_pkg;
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_UP1 = 3'h1,
        ST_UP2 = 3'h2,
        ST_RUN = 3'h3,
        ST_FAILDLY = 3'h4,
        ST_DN1 = 3'h5,
        ST_DN2 = 3'h6
    } rss_state_t;
endpackage

// File: rtl/rss_pg_if.sv
// comparator results and enables between sequencer and power-good monitor
interface rss_pg_if #(parameter int N = 4);
    logic [N-1:0] below;
    logic [N-1:0] recov;
    logic [N-1:0] enable;
    logic [N-1:0] fault;
    modport mon (input below, input recov, input enable, output fault);
    modport ctl (output below, output recov, output enable, input fault);
endinterface

// File: rtl/rss_pgood_mon.sv
// power-good hysteresis monitor for all rails
module rss_pgood_mon #(
    parameter int N = 4
) (
    input wire logic clk,
    input wire logic rst,
    rss_pg_if.mon pg
);
    logic [N-1:0] below_s1_q, below_s2_q, below_s3_q, below_f_q;
    logic [N-1:0] recov_s1_q, recov_s2_q, recov_s3_q, recov_f_q;
    logic [N-1:0] fault_q;

    // comparators are asynchronous to CLOCK
    always_ff @(posedge clk) begin
        if (rst) begin
            below_s1_q <= '0;
            below_s2_q <= '0;
            below_s3_q <= '0;
            recov_s1_q <= '0;
            recov_s2_q <= '0;
            recov_s3_q <= '0;
        end else begin
            below_s1_q <= pg.below;
            below_s2_q <= below_s1_q;
            below_s3_q <= below_s2_q;
            recov_s1_q <= pg.recov;
            recov_s2_q <= recov_s1_q;
            recov_s3_q <= recov_s2_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            below_f_q <= '0;
            recov_f_q <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (below_s2_q[i] == below_s3_q[i])
                    below_f_q[i] <= below_s3_q[i];
                if (recov_s2_q[i] == recov_s3_q[i])
                    recov_f_q[i] <= recov_s3_q[i];
            end
        end
    end

    // fault below 90%, cleared above 95% or while the rail is disabled
    always_ff @(posedge clk) begin
        if (rst) begin
            fault_q <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (!pg.enable[i])
                    fault_q[i] <= 1'b0;
                else if (below_f_q[i])
                    fault_q[i] <= 1'b1;
                else if (recov_f_q[i])
                    fault_q[i] <= 1'b0;
            end
        end
    end

    assign pg.fault = fault_q;

    chk_pg_disabled_clear: assert property (@(posedge clk) disable iff (rst)
        !pg.enable[0] |=> !fault_q[0])
        else $error("disabled rail shows a fault");
endmodule

// File: tb/rss_rail_model.sv
// behavioural regulator outputs and comparators facing the supervisor
module rss_rail_model (
    input wire logic clk,
    input wire logic [3:0] en,
    input wire logic [3:0] droop,
    output logic [3:0] below,
    output logic [3:0] recov
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] s1_q = 4'h0;
    logic [3:0] s2_q = 4'h0;
    logic [3:0] s3_q = 4'h0;
    // short ramp so the rail sits between thresholds for a while
    always_ff @(posedge clk) begin
        s1_q <= en & ~droop;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
    // a switched-off rail reads below on the next cycle; its recov level stays high two cycles longer
    assign below = ~s1_q | droop;
    assign recov = s3_q & ~droop;
endmodule

// File: tb/rss_top_bench.sv
// self-checking bench of the rail supervisor
`include "rss_defs.svh"
module rss_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] padr = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic prdy, perr, e;
    logic [3:0] below, recov, droop = 4'h0;
    logic uv = 1'b0, ot = 1'b0, cot = 1'b0, ac = 1'b0, usb = 1'b0;
    logic apwm = 1'b0, rds = 1'b0, seq = 1'b0;
    logic [3:0] mvs, cvs;
    logic [2:0] l1vs, l2vs;
    logic m_en, c_en, l1_en, l2_en, forced_pwm_bit, sw_blk, chg, por_n, sf_n, int_n;
    logic [1:0] uvsel;
    int err_total = 0, n_checks = 0, cyc = 0;
    rss_top #(.POR_SHORT_CYC(40), .POR_LONG_CYC(100)) i_rss_top (
        .CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
        .PSLVERR(perr), .RAIL_BELOW(below), .RAIL_RECOV(recov),
        .UNDERVOLTAGE_LOCKOUT_DET(uv), .OVERTEMP_DET(ot),
        .CONV_OT_DET(cot), .AUTO_PWM(apwm), .AC_LOW(ac), .USB_LOW(usb),
        .SEQUENCE_ORDER_PIN(seq), .CORE_DEFAULT_STRAP(1'b0),
        .MAIN_DEFAULT_STRAP(1'b1), .RESET_DELAY_SELECT(rds),
        .MAIN_RAIL_EN(m_en), .CORE_RAIL_EN(c_en),
        .LINEAR_REG_ONE_EN(l1_en), .LINEAR_REG_TWO_EN(l2_en),
        .LINEAR_REG_ONE_VSEL(l1vs), .LINEAR_REG_TWO_VSEL(l2vs),
        .MAIN_RAIL_VSEL(mvs), .CORE_RAIL_VSEL(cvs), .FORCED_PWM_BIT(forced_pwm_bit),
        .UNDERVOLTAGE_LOCKOUT_SEL(uvsel), .SWITCH_BLOCK(sw_blk),
        .CHARGER_LOCKOUT(chg), .POWER_ON_RESET_OUT_N(por_n),
        .SUPPLY_FAIL_OUT_N(sf_n), .INT_N(int_n)
    );
    rss_rail_model i_rss_rail_model (
        .clk(clk), .en({l2_en, l1_en, c_en, m_en}), .droop(droop),
        .below(below), .recov(recov)
    );
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, got);
        n_checks++;
        if (got !== ex) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // request held until pready is seen, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (prdy !== 1'b1 && k < 50);
        chk("pready", 32'h1, {31'h0, prdy});
        rd = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
        input logic [31:0] m, ex);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, rd & m);
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return m_en;
            1: return c_en;
            2: return por_n;
            3: return sf_n;
            default: return int_n;
        endcase
    endfunction
    task automatic wait_chk(input string nm, input int s, input logic v,
        input int lim);
        int k;
        for (k = 0; k < lim && pick(s) !== v; k++) @(posedge clk);
        chk(nm, {31'h0, v}, {31'h0, pick(s)});
    endtask
    task automatic shut(input logic kind);
        wait_chk("fail_idle", 3, 1'b1, 200);
        if (kind) ot <= 1'b1;
        else uv <= 1'b1;
        wait_chk("fail_low", 3, 1'b0, 12);
        if (kind) begin
            chk("main_held", 32'h1, {31'h0, m_en});
            wait_chk("main_off", 0, 1'b0, 1400);
            chk("core_last", 32'h1, {31'h0, c_en});
            wait_chk("core_off", 1, 1'b0, 700);
        end else begin
            chk("sw_block", 32'h1, {31'h0, sw_blk});
            chk("core_blocked", 32'h0, {31'h0, c_en});
            chk("main_blocked", 32'h0, {31'h0, m_en});
            // hold lockout past the whole ordered shutdown
            repeat (1800) @(posedge clk);
            chk("ldo_off", 32'h0, {31'h0, l1_en});
        end
        ot <= 1'b0;
        uv <= 1'b0;
        wait_chk("main_back", 0, 1'b1, 4000);
        repeat (kind ? 30 : 90) @(posedge clk);
        chk("por_held", 32'h0, {31'h0, por_n});
        wait_chk("restart", 2, 1'b1, 60);
        $display("test shutdown %0d done", kind);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        rdc("ldo", `RSS_ADDR_LDO, 32'hFFFFFFFF, 32'h3);
        rdc("undervoltage_lockout", `RSS_ADDR_UNDERVOLTAGE_LOCKOUT, 32'hFFFFFFFF, 32'h3);
        rdc("vsel", `RSS_ADDR_VSEL, 32'hFFFFFFFF, 32'h503);
        chk("vsel_pins", 32'h53, {24'h0, cvs, mvs});
        apb(1'b0, 8'h3C, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        wait_chk("core_first", 1, 1'b1, 700);
        chk("main_later", 32'h0, {31'h0, m_en});
        wait_chk("main_up", 0, 1'b1, 700);
        chk("fail_during_por", 32'h0, {31'h0, sf_n});
        wait_chk("por_high", 2, 1'b1, 300);
        wait_chk("fail_high", 3, 1'b1, 5);
        wait_chk("int_idle", 4, 1'b1, 700);
        rdc("status", `RSS_ADDR_STATUS, 32'hF, 32'hF);
        $display("test startup done");
        droop <= 4'h4;
        wait_chk("int_linear_reg_one", 4, 1'b0, 20);
        apb(1'b1, `RSS_ADDR_MASK, 32'h4);
        wait_chk("int_masked", 4, 1'b1, 10);
        rdc("status_live", `RSS_ADDR_STATUS, 32'hF, 32'hB);
        droop <= 4'h0;
        apb(1'b1, `RSS_ADDR_MASK, 32'h0);
        repeat (20) @(posedge clk);
        chk("int_clear", 32'h1, {31'h0, int_n});
        $display("test interrupt done");
        apb(1'b1, `RSS_ADDR_CONV, 32'h1);
        apb(1'b1, `RSS_ADDR_LDO, 32'h1);
        repeat (20) @(posedge clk);
        chk("core_dis", 32'h0, {31'h0, c_en});
        chk("linear_reg_two_dis", 32'h0, {31'h0, l2_en});
        chk("int_dis", 32'h1, {31'h0, int_n});
        rdc("status_dis", `RSS_ADDR_STATUS, 32'hF, 32'hF);
        apb(1'b1, `RSS_ADDR_LDO, 32'h523);
        chk("ldo_vsel", 32'h52, {24'h0, 1'b0, l2vs, 1'b0, l1vs});
        apb(1'b1, `RSS_ADDR_UNDERVOLTAGE_LOCKOUT, 32'h1);
        chk("undervoltage_lockout_sel", 32'h1, {30'h0, uvsel});
        apb(1'b1, `RSS_ADDR_UNDERVOLTAGE_LOCKOUT, 32'h3);
        cot <= 1'b1;
        repeat (10) @(posedge clk);
        chk("ot_no_pwm", 32'h1, {31'h0, m_en});
        apwm <= 1'b1;
        wait_chk("ot_auto_off", 0, 1'b0, 10);
        apwm <= 1'b0;
        wait_chk("ot_auto_back", 0, 1'b1, 10);
        apb(1'b1, `RSS_ADDR_CONV, 32'h83);
        chk("forced_pwm_bit", 32'h1, {31'h0, forced_pwm_bit});
        wait_chk("ot_pwm_off", 0, 1'b0, 10);
        chk("ot_core_off", 32'h0, {31'h0, c_en});
        cot <= 1'b0;
        apb(1'b1, `RSS_ADDR_CONV, 32'h3);
        $display("test controls done");
        ac <= 1'b1;
        repeat (10) @(posedge clk);
        chk("chg_one_low", 32'h0, {31'h0, chg});
        usb <= 1'b1;
        repeat (10) @(posedge clk);
        chk("chg_both_low", 32'h1, {31'h0, chg});
        ac <= 1'b0;
        usb <= 1'b0;
        $display("test charger done");
        shut(1'b1);
        rds <= 1'b1;
        shut(1'b0);
        seq <= 1'b1;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(posedge clk);
        seq <= 1'b0;
        wait_chk("main_first", 0, 1'b1, 700);
        chk("core_later", 32'h0, {31'h0, c_en});
        wait_chk("core_up", 1, 1'b1, 700);
        $display("test reorder done");
        print_verdict();
    end
endmodule
